// ==== core/ssof_top.sv ====
// servo status output flags with apb configuration and interrupt
`timescale 1ns/100ps
module ssof_top
  import ssof_pkg::*;
#(
  parameter int POWER_ON_CYC = POWER_ON_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssof_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // motion state from the amplifier
  input wire logic signed [15:0] motor_speed_in,
  input wire logic signed [15:0] gen_torque_in,
  input wire logic [15:0] analog_torque_limit_in,
  input wire logic signed [31:0] actual_position_in,
  // drive state from the amplifier
  input wire logic servo_on_in,
  input wire logic alarm_in,
  input wire logic base_circuit_on_in,
  input wire logic dyn_brake_active_in,
  input wire logic home_return_done_in,
  input wire logic gain_switched_in,
  // warnings from the amplifier
  input wire logic warning_present_in,
  input wire logic open_battery_cable_warning,
  input wire logic low_battery_warning,
  // commanded speed profile
  input wire logic cmd_speed_zero_in,
  input wire logic cmd_speed_ramping_in,
  input wire logic cmd_speed_at_target_in,
  // status flag outputs
  output logic zero_speed_flag,
  output logic torque_limiting_flag,
  output logic warning_flag,
  output logic brake_interlock_out,
  output logic dynamic_brake_interlock_out,
  output logic battery_warning_flag,
  output logic position_range_flag,
  output logic gain_switching_flag,
  output logic speed_reached_flag,
  // interrupt
  output logic irq
);

  // all state of this module in one record; the zero-speed detector and settle timer keep their own
  typedef struct packed {
    logic [15:0] zs_level;
    logic [15:0] fwd_tlim;
    logic [15:0] rev_tlim;
    logic [31:0] pos_lo;
    logic [31:0] pos_hi;
    logic [NFLAGS-1:0] flags;
    logic [NFLAGS-1:0] int_status;
    logic [NFLAGS-1:0] int_enable;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssof_state_t;

  ssof_state_t s_reg;
  ssof_state_t s_next;

  logic zs_det;
  logic settled;
  logic [15:0] trq_mag;
  logic trq_hit;
  logic pos_in;
  logic [NFLAGS-1:0] flag_raw;
  logic [NFLAGS-1:0] flag_rise;
  logic [NFLAGS-1:0] clr_mask;
  logic acc_first;
  logic acc_write;
  logic mapped;
  logic [31:0] rd_data;

  // word decode of an apb address against a byte offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // zero-speed comparator with its own hysteresis state
  ssof_zero_speed u_zero_speed (
    .pclk(pclk),
    .presetn(presetn),
    .speed(motor_speed_in),
    .level(s_reg.zs_level),
    .zero_speed(zs_det)
  );

  // power-on window for the two warning flags
  ssof_settle_timer #(
    .CYCLES(POWER_ON_CYC)
  ) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .done(settled)
  );

  // torque magnitude, saturating on the most negative code
  always_comb begin
    if (gen_torque_in == 16'sh8000) begin
      trq_mag = 16'h7fff;
    end else if (gen_torque_in[15]) begin
      trq_mag = 16'(-gen_torque_in);
    end else begin
      trq_mag = 16'(gen_torque_in);
    end
  end

  // positive torque meets the forward limit, negative the reverse limit,
  // either sign the analog limit
  assign trq_hit = (!gen_torque_in[15] && (trq_mag >= s_reg.fwd_tlim))
                || (gen_torque_in[15] && (trq_mag >= s_reg.rev_tlim))
                || (trq_mag >= analog_torque_limit_in);

  // inclusive window, signed compare
  assign pos_in = ($signed(actual_position_in) >= $signed(s_reg.pos_lo))
               && ($signed(actual_position_in) <= $signed(s_reg.pos_hi));

  // combinational value of each flag before registering
  always_comb begin
    flag_raw = '0;
    flag_raw[FLG_ZERO_SPEED] = zs_det;
    flag_raw[FLG_TORQUE_LIM] = trq_hit;
    // warnings read active until the settle window ends
    flag_raw[FLG_WARNING] = settled ? warning_present_in : 1'b1;
    // alarm drops the brake interlock whatever the base circuit does
    flag_raw[FLG_BRAKE] = servo_on_in && !alarm_in;
    flag_raw[FLG_DYN_BRAKE] = !dyn_brake_active_in;
    flag_raw[FLG_BATTERY] = settled ? (open_battery_cable_warning || low_battery_warning) : 1'b1;
    flag_raw[FLG_POSITION] = pos_in && home_return_done_in && base_circuit_on_in;
    flag_raw[FLG_GAIN_SW] = gain_switched_in;
    // zero command wins over the ramp indication
    flag_raw[FLG_SPEED_REACHED] = servo_on_in
                               && (cmd_speed_zero_in
                                   || (cmd_speed_at_target_in && !cmd_speed_ramping_in));
  end

  // rising edges of the flags raise the interrupt events
  assign flag_rise = flag_raw & ~s_reg.flags;

  // apb phases: first access cycle loads read data, second completes
  assign acc_first = psel && penable && !s_reg.pready;
  assign acc_write = psel && penable && s_reg.pready && pwrite;

  // address map
  assign mapped = hit(paddr, OFS_ZS_LEVEL) || hit(paddr, OFS_FWD_TLIM)
               || hit(paddr, OFS_REV_TLIM) || hit(paddr, OFS_POS_LO)
               || hit(paddr, OFS_POS_HI) || hit(paddr, OFS_FLAGS)
               || hit(paddr, OFS_INT_STATUS) || hit(paddr, OFS_INT_ENABLE)
               || hit(paddr, OFS_INT_CLEAR) || hit(paddr, OFS_SPEED_MON);

  // read mux; the clear register is write-only and reads zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit(paddr, OFS_ZS_LEVEL)) begin
      rd_data = {16'h0000, s_reg.zs_level};
    end else if (hit(paddr, OFS_FWD_TLIM)) begin
      rd_data = {16'h0000, s_reg.fwd_tlim};
    end else if (hit(paddr, OFS_REV_TLIM)) begin
      rd_data = {16'h0000, s_reg.rev_tlim};
    end else if (hit(paddr, OFS_POS_LO)) begin
      rd_data = s_reg.pos_lo;
    end else if (hit(paddr, OFS_POS_HI)) begin
      rd_data = s_reg.pos_hi;
    end else if (hit(paddr, OFS_FLAGS)) begin
      rd_data = {{(32-NFLAGS){1'b0}}, s_reg.flags};
    end else if (hit(paddr, OFS_INT_STATUS)) begin
      rd_data = {{(32-NFLAGS){1'b0}}, s_reg.int_status};
    end else if (hit(paddr, OFS_INT_ENABLE)) begin
      rd_data = {{(32-NFLAGS){1'b0}}, s_reg.int_enable};
    end else if (hit(paddr, OFS_SPEED_MON)) begin
      // live speed, sign-extended, for software debug
      rd_data = {{16{motor_speed_in[15]}}, motor_speed_in};
    end
  end

  // write-one-to-clear mask, only during a completing write
  assign clr_mask = (acc_write && hit(paddr, OFS_INT_CLEAR)) ? pwdata[NFLAGS-1:0] : '0;

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (acc_first) begin
      s_next.pready = 1'b1;
      s_next.pslverr = !mapped;
      s_next.prdata = pwrite ? 32'h0000_0000 : rd_data;
    end
    // writes take effect only at the edge that completes the transfer
    if (acc_write) begin
      if (hit(paddr, OFS_ZS_LEVEL)) begin
        s_next.zs_level = pwdata[15:0];
      end
      if (hit(paddr, OFS_FWD_TLIM)) begin
        s_next.fwd_tlim = pwdata[15:0];
      end
      if (hit(paddr, OFS_REV_TLIM)) begin
        s_next.rev_tlim = pwdata[15:0];
      end
      if (hit(paddr, OFS_POS_LO)) begin
        s_next.pos_lo = pwdata;
      end
      if (hit(paddr, OFS_POS_HI)) begin
        s_next.pos_hi = pwdata;
      end
      if (hit(paddr, OFS_INT_ENABLE)) begin
        s_next.int_enable = pwdata[NFLAGS-1:0];
      end
    end
    // all outputs pass one register stage here; zero_speed_flag also passes the detector's register first
    s_next.flags = flag_raw;
    // an event in the clearing cycle survives: set beats clear
    s_next.int_status = (s_reg.int_status & ~clr_mask) | flag_rise;
    s_next.irq = |(s_next.int_status & s_next.int_enable);
  end

  // state register; warning flags come out of reset active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.zs_level <= ZS_LEVEL_RST;
      s_reg.fwd_tlim <= FWD_TLIM_RST;
      s_reg.rev_tlim <= REV_TLIM_RST;
      s_reg.pos_lo <= POS_LO_RST;
      s_reg.pos_hi <= POS_HI_RST;
      s_reg.flags <= FLAGS_RST;
      s_reg.int_status <= '0;
      s_reg.int_enable <= '0;
      s_reg.irq <= 1'b0;
      s_reg.pready <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.prdata <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq = s_reg.irq;
  assign zero_speed_flag = s_reg.flags[FLG_ZERO_SPEED];
  assign torque_limiting_flag = s_reg.flags[FLG_TORQUE_LIM];
  assign warning_flag = s_reg.flags[FLG_WARNING];
  assign brake_interlock_out = s_reg.flags[FLG_BRAKE];
  assign dynamic_brake_interlock_out = s_reg.flags[FLG_DYN_BRAKE];
  assign battery_warning_flag = s_reg.flags[FLG_BATTERY];
  assign position_range_flag = s_reg.flags[FLG_POSITION];
  assign gain_switching_flag = s_reg.flags[FLG_GAIN_SW];
  assign speed_reached_flag = s_reg.flags[FLG_SPEED_REACHED];

endmodule // ssof_top

// ==== core/ssof_pkg.sv ====
// shared constants for the servo status output flag block
package ssof_pkg;

  // clock rate and power-on settle time
  localparam int CLK_HZ = 40_000_000;
  localparam int POWER_ON_TIME_MS = 1000;
  // longest time rounds down to whole cycles
  localparam int POWER_ON_CYCLES = (CLK_HZ / 1000) * POWER_ON_TIME_MS;

  // zero-speed detection
  localparam logic [15:0] ZS_LEVEL_RST = 16'h0032;  // 50 r/min
  localparam logic [15:0] ZS_HYST_RPM = 16'h0014;   // 20 r/min, fixed

  // torque limit reset values, in the same unit as the torque input
  localparam logic [15:0] FWD_TLIM_RST = 16'h03e8;
  localparam logic [15:0] REV_TLIM_RST = 16'h03e8;

  // position window reset values
  localparam logic [31:0] POS_LO_RST = 32'h0000_0000;
  localparam logic [31:0] POS_HI_RST = 32'h0000_0000;

  // apb address width and register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_ZS_LEVEL = 12'h000;
  localparam logic [11:0] OFS_FWD_TLIM = 12'h004;
  localparam logic [11:0] OFS_REV_TLIM = 12'h008;
  localparam logic [11:0] OFS_POS_LO = 12'h00c;
  localparam logic [11:0] OFS_POS_HI = 12'h010;
  localparam logic [11:0] OFS_FLAGS = 12'h014;
  localparam logic [11:0] OFS_INT_STATUS = 12'h018;
  localparam logic [11:0] OFS_INT_ENABLE = 12'h01c;
  localparam logic [11:0] OFS_INT_CLEAR = 12'h020;
  localparam logic [11:0] OFS_SPEED_MON = 12'h024;

  // flag bit positions, shared by flags, status, enable and clear registers
  localparam int NFLAGS = 9;
  localparam int FLG_ZERO_SPEED = 0;
  localparam int FLG_TORQUE_LIM = 1;
  localparam int FLG_WARNING = 2;
  localparam int FLG_BRAKE = 3;
  localparam int FLG_DYN_BRAKE = 4;
  localparam int FLG_BATTERY = 5;
  localparam int FLG_POSITION = 6;
  localparam int FLG_GAIN_SW = 7;
  localparam int FLG_SPEED_REACHED = 8;

  // warning flags sit active until the power-on window has elapsed
  localparam logic [8:0] FLAGS_RST = 9'h024;

endpackage

// ==== core/ssof_zero_speed.sv ====
// zero-speed detector with fixed hysteresis
`timescale 1ns/100ps
module ssof_zero_speed
  import ssof_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // speed and configured level
  input wire logic signed [15:0] speed,
  input wire logic [15:0] level,
  // detector output
  output logic zero_speed
);

  typedef struct packed {
    logic zs;
  } ssof_zs_state_t;

  ssof_zs_state_t s_reg;
  ssof_zs_state_t s_next;
  logic [15:0] mag;
  logic [16:0] off_level;

  // magnitude saturates at the most negative code instead of wrapping
  always_comb begin
    if (speed == 16'sh8000) begin
      mag = 16'h7fff;
    end else if (speed[15]) begin
      mag = 16'(-speed);
    end else begin
      mag = 16'(speed);
    end
    off_level = {1'b0, level} + {1'b0, ZS_HYST_RPM};
    s_next = s_reg;
    if (!s_reg.zs && ({1'b0, mag} <= {1'b0, level})) begin
      s_next.zs = 1'b1;
    end else if (s_reg.zs && ({1'b0, mag} >= off_level)) begin
      s_next.zs = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign zero_speed = s_reg.zs;

endmodule // ssof_zero_speed

// ==== core/ssof_settle_timer.sv ====
// one-shot power-on settle timer
`timescale 1ns/100ps
module ssof_settle_timer #(
  parameter int CYCLES = 40_000_000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // high once the window has elapsed
  output logic done
);

  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } ssof_tmr_state_t;

  ssof_tmr_state_t s_reg;
  ssof_tmr_state_t s_next;

  // counts once after reset, then parks with done held high
  always_comb begin
    s_next = s_reg;
    if (!s_reg.done) begin
      if (s_reg.cnt == LAST) begin
        s_next.done = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;

endmodule // ssof_settle_timer

// ==== test/ssof_top_asserts.sv ====
// assertion checker for the status flag outputs
`timescale 1ns/100ps
module ssof_top_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // amplifier state
  input wire logic signed [15:0] motor_speed_in,
  input wire logic servo_on_in, alarm_in, base_circuit_on_in, dyn_brake_active_in,
  input wire logic home_return_done_in, gain_switched_in, warning_present_in,
  input wire logic open_battery_cable_warning, low_battery_warning,
  input wire logic cmd_speed_zero_in, cmd_speed_ramping_in, cmd_speed_at_target_in,
  // flags
  input wire logic zero_speed_flag, warning_flag, brake_interlock_out, dynamic_brake_interlock_out,
  input wire logic battery_warning_flag, position_range_flag, gain_switching_flag, speed_reached_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the $past(presetn) terms keep the reset-release edge out of the brake and dynamic brake antecedents
  AST_ZERO_SPEED: assert property ((presetn && motor_speed_in == 16'sh0000) [*3] |=> zero_speed_flag)
    else $error("zero speed flag missing");
  AST_WARNING: assert property (presetn && warning_present_in |=> warning_flag)
    else $error("warning flag missing");
  AST_BRAKE: assert property (presetn && $past(presetn) |->
    brake_interlock_out == ($past(servo_on_in) && !$past(alarm_in))) else $error("brake interlock wrong");
  AST_DYN_BRAKE: assert property (presetn && $past(presetn) |->
    dynamic_brake_interlock_out == !$past(dyn_brake_active_in)) else $error("dynamic brake interlock wrong");
  AST_BATTERY: assert property (presetn && (open_battery_cable_warning || low_battery_warning) |=>
    battery_warning_flag) else $error("battery flag missing");
  AST_POS_OFF: assert property (presetn && !(home_return_done_in && base_circuit_on_in) |=>
    !position_range_flag) else $error("position flag without home or base");
  AST_GAIN: assert property (presetn && $rose(gain_switched_in) |=> gain_switching_flag)
    else $error("gain flag missing");
  AST_AT_TARGET: assert property (presetn && servo_on_in && cmd_speed_at_target_in &&
    !cmd_speed_ramping_in |=> speed_reached_flag) else $error("speed reached missing at target");
  AST_CMD_ZERO: assert property (presetn && servo_on_in && cmd_speed_zero_in |=> speed_reached_flag)
    else $error("speed reached missing at zero command");
  AST_SR_OFF: assert property (presetn && (!servo_on_in || (cmd_speed_ramping_in && !cmd_speed_zero_in)) |=>
    !speed_reached_flag) else $error("speed reached while off or ramping");
endmodule // ssof_top_asserts

bind ssof_top ssof_top_asserts ssof_top_asserts_i (.pclk, .presetn, .motor_speed_in, .servo_on_in, .alarm_in,
  .base_circuit_on_in, .dyn_brake_active_in, .home_return_done_in, .gain_switched_in, .warning_present_in,
  .open_battery_cable_warning, .low_battery_warning, .cmd_speed_zero_in, .cmd_speed_ramping_in,
  .cmd_speed_at_target_in, .zero_speed_flag, .warning_flag, .brake_interlock_out, .dynamic_brake_interlock_out,
  .battery_warning_flag, .position_range_flag, .gain_switching_flag, .speed_reached_flag);

// ==== test/ssof_host_model.sv ====
// host controller model that samples the status flags
`timescale 1ns/100ps
module ssof_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flags in, host view out
  input wire logic [8:0] flags,
  output logic [8:0] seen
);
  // one-cycle input latch; the bench settles long enough to cover it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen <= '0;
    else seen <= flags;
  end
endmodule // ssof_host_model

// ==== test/ssof_top_tb.sv ====
// self-checking bench for the status flag block
`timescale 1ns/100ps
module ssof_top_tb;
  import ssof_pkg::*;
  localparam int PON = 20;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic signed [15:0] motor_speed_in = '0, gen_torque_in = '0;
  logic [15:0] analog_torque_limit_in = '1;
  logic signed [31:0] actual_position_in = '0;
  logic servo_on_in = '0, alarm_in = '0, base_circuit_on_in = '0, dyn_brake_active_in = '0;
  logic home_return_done_in = '0, gain_switched_in = '0, warning_present_in = '0;
  logic open_battery_cable_warning = '0, low_battery_warning = '0;
  logic cmd_speed_zero_in = '0, cmd_speed_ramping_in = '0, cmd_speed_at_target_in = '0;
  logic pready, pslverr, irq, er;
  // each flag bit is driven by its own output port, so the bus is a net
  wire [8:0] flags;
  logic [8:0] seen;
  int miscompares = 0, tests_run = 0;
  always #12.5 pclk = ~pclk;
  ssof_top #(.POWER_ON_CYC(PON)) ssof_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .motor_speed_in, .gen_torque_in, .analog_torque_limit_in, .actual_position_in, .servo_on_in,
    .alarm_in, .base_circuit_on_in, .dyn_brake_active_in, .home_return_done_in, .gain_switched_in,
    .warning_present_in, .open_battery_cable_warning, .low_battery_warning, .cmd_speed_zero_in,
    .cmd_speed_ramping_in, .cmd_speed_at_target_in, .zero_speed_flag(flags[0]), .torque_limiting_flag(flags[1]),
    .warning_flag(flags[2]), .brake_interlock_out(flags[3]), .dynamic_brake_interlock_out(flags[4]),
    .battery_warning_flag(flags[5]), .position_range_flag(flags[6]), .gain_switching_flag(flags[7]),
    .speed_reached_flag(flags[8]), .irq);
  ssof_host_model ssof_host_model_i (.pclk, .presetn, .flags, .seen);
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // settle past the flag register and the host latch, then look
  task fl(input int b, input logic e);
    repeat (4) @(posedge pclk);
    chk($sformatf("flag %0d", b), {31'h0, e}, {31'h0, seen[b]});
  endtask
  // one apb transfer; held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task irqchk(input logic e);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task t_power_on;
    chk("warn in window", 32'h1, {31'h0, flags[FLG_WARNING]});
    chk("battery in window", 32'h1, {31'h0, flags[FLG_BATTERY]});
    chk("brake in reset", 32'h0, {31'h0, flags[FLG_BRAKE]});
    apb(1'h0, OFS_ZS_LEVEL, '0);
    chk("level reset", 32'h32, rd);
    repeat (PON) @(posedge pclk);
    fl(FLG_WARNING, 1'h0);
    fl(FLG_BATTERY, 1'h0);
    low_battery_warning <= 1'h1;
    fl(FLG_BATTERY, 1'h1);
    low_battery_warning <= 1'h0;
    open_battery_cable_warning <= 1'h1;
    fl(FLG_BATTERY, 1'h1);
    open_battery_cable_warning <= 1'h0;
    warning_present_in <= 1'h1;
    fl(FLG_WARNING, 1'h1);
    warning_present_in <= 1'h0;
    fl(FLG_WARNING, 1'h0);
  endtask
  // walks both hysteresis edges in both directions, then with a raised level
  task t_zero_speed;
    logic signed [15:0] sp [11] = '{16'sh003c, 16'sh0032, 16'sh0045, 16'sh0046, -16'sh0032, -16'sh0045,
      -16'sh0046, 16'sh0065, 16'sh0064, 16'sh0077, 16'sh0078};
    // the flag is already on from standstill, so the first step stays inside the hysteresis
    logic [10:0] ex = 11'h337;
    for (int i = 0; i < 11; i++) begin
      motor_speed_in <= sp[i];
      // move the speed first: raising the level while still at -70 r/min would set the flag early
      if (i == 7) apb(1'h1, OFS_ZS_LEVEL, 32'h64);
      fl(FLG_ZERO_SPEED, ex[i]);
    end
  endtask
  task t_torque;
    logic signed [15:0] tq [5] = '{16'sh00ff, 16'sh0100, -16'sh01ff, -16'sh0200, 16'sh0050};
    logic [4:0] ex = 5'h1a;
    apb(1'h1, OFS_FWD_TLIM, 32'h100);
    apb(1'h1, OFS_REV_TLIM, 32'h200);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) analog_torque_limit_in <= 16'h0050;
      gen_torque_in <= tq[i];
      fl(FLG_TORQUE_LIM, ex[i]);
    end
  endtask
  task t_drive;
    apb(1'h1, OFS_POS_LO, 32'ha);
    apb(1'h1, OFS_POS_HI, 32'h14);
    actual_position_in <= 32'sh0f;
    home_return_done_in <= 1'h1;
    base_circuit_on_in <= 1'h1;
    servo_on_in <= 1'h1;
    cmd_speed_ramping_in <= 1'h1;
    cmd_speed_at_target_in <= 1'h1;
    fl(FLG_POSITION, 1'h1);
    chk("ramping", 32'h0, {31'h0, seen[FLG_SPEED_REACHED]});
    chk("brake on", 32'h1, {31'h0, seen[FLG_BRAKE]});
    actual_position_in <= 32'sh15;
    alarm_in <= 1'h1;
    cmd_speed_ramping_in <= 1'h0;
    fl(FLG_POSITION, 1'h0);
    chk("brake alarm", 32'h0, {31'h0, seen[FLG_BRAKE]});
    chk("at target", 32'h1, {31'h0, seen[FLG_SPEED_REACHED]});
    actual_position_in <= 32'sh14;
    dyn_brake_active_in <= 1'h1;
    fl(FLG_DYN_BRAKE, 1'h0);
    chk("edge of window", 32'h1, {31'h0, seen[FLG_POSITION]});
    base_circuit_on_in <= 1'h0;
    servo_on_in <= 1'h0;
    fl(FLG_POSITION, 1'h0);
    chk("servo off", 32'h0, {31'h0, seen[FLG_SPEED_REACHED]});
    base_circuit_on_in <= 1'h1;
    home_return_done_in <= 1'h0;
    servo_on_in <= 1'h1;
    cmd_speed_zero_in <= 1'h1;
    cmd_speed_ramping_in <= 1'h1;
    cmd_speed_at_target_in <= 1'h0;
    fl(FLG_POSITION, 1'h0);
    chk("zero command", 32'h1, {31'h0, seen[FLG_SPEED_REACHED]});
  endtask
  task t_irq;
    apb(1'h1, OFS_INT_CLEAR, 32'h1ff);
    apb(1'h1, OFS_INT_ENABLE, 32'h80);
    irqchk(1'h0);
    gain_switched_in <= 1'h1;
    fl(FLG_GAIN_SW, 1'h1);
    irqchk(1'h1);
    apb(1'h1, OFS_INT_ENABLE, 32'h0);
    irqchk(1'h0);
    apb(1'h1, OFS_INT_ENABLE, 32'h80);
    irqchk(1'h1);
    gain_switched_in <= 1'h0;
    apb(1'h1, OFS_INT_CLEAR, 32'h80);
    irqchk(1'h0);
    apb(1'h0, OFS_INT_STATUS, '0);
    chk("status cleared", 32'h0, rd & 32'h80);
    apb(1'h0, 12'h040, '0);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'h0, OFS_INT_CLEAR, '0);
    chk("clear reads zero", 32'h0, rd);
  endtask
  task report_and_stop;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_power_on();
    t_zero_speed();
    t_torque();
    t_drive();
    t_irq();
    report_and_stop();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge pclk);
    chk("watchdog", 32'h0, 32'h1);
    report_and_stop();
  end
endmodule // ssof_top_tb
